// file: pkg/strap_latch_pkg.sv
// types shared by the strap latch and boot configuration block
package strap_latch_pkg;

	typedef enum logic [1:0] {
		BOOT_UNDEFINED,
		BOOT_FLASH,
		BOOT_DOWNLOAD
	} bootMode_t;

	typedef enum logic [1:0] {
		DBG_PADS,
		DBG_USB,
		DBG_OFF
	} debugSource_t;

	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_HOLD,
		PWR_RUN
	} pwrState_t;

	typedef logic [4:0] strapVec_t;

endpackage

// file: pkg/strap_latch_regs.svh
// constants for the strap latch and boot configuration block
//
// How it works
// - power pin held high keeps the device active and powered.
// - power pin low powers down; releasing it high restarts power-up.
// - each strap level is captured into its own latch at every reset.
// - latches keep their value until the device powers down.
// - only reset-time sampling changes latches; writes and pin activity cannot.
// - after capture the strap pins return to general-purpose IO use.
// - weak pull-up on the second boot strap during reset; floating reads 1.
// - sample only after the power pin rises; release pins after a hold time.
// - boot mode from both boot straps; second strap 1 means flash boot.
// - first strap 1 with second strap 0 selects combined download boot.
// - flash boot loads and runs the program from serial flash.
// - sample-edge strap 0 samples on falling edge, 1 on rising edge.
// - drive-edge strap 0 launches on falling edge, 1 on rising edge.
// - first boot strap also feeds the boot message print decision.
// - a separate strap selects the early-boot debug signal source.
// - print fuse 00 prints, 01 prints on strap 0, 10 on strap 1, 11 never.
// - fuses clear and select set: debug strap 0 gives pads, 1 gives USB.
`ifndef STRAP_LATCH_REGS_SVH
`define STRAP_LATCH_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_STATUS        4'h0
`define REG_LATCHED       4'h4
`define REG_PIN_LEVEL     4'h8
`define REG_GPIO_OUT      4'hC

// ----------------------------------------------------------------
// strap bit positions
// ----------------------------------------------------------------
`define STRAP_BOOT_FIRST  0
`define STRAP_BOOT_SECOND 1
`define STRAP_SAMPLE_EDGE 2
`define STRAP_DRIVE_EDGE  3
`define STRAP_DEBUG_SRC   4
`define STRAP_COUNT       5

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ST_ACTIVE_BIT     0
`define ST_VALID_BIT      1
`define ST_BOOT_LSB       2
`define ST_SAMPLE_BIT     4
`define ST_DRIVE_BIT      5
`define ST_PRINT_BIT      6
`define ST_DEBUG_LSB      7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LATCH_RESET       5'h00
`define GPIO_OUT_RESET    5'h00
`define GPIO_OE_LSB       8
`define GPIO_OE_RESET     5'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ           20000
`define STRAP_HOLD_MS     1
`define STRAP_HOLD_CYC    (`STRAP_HOLD_MS * `CLK_KHZ)

`endif

// file: src/strap_latch_boot_config.sv
// strap latching, boot configuration decode and register slave
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "strap_latch_regs.svh"
module strap_latch_boot_config
	import strap_latch_pkg::*;
#(
	parameter logic [15:0] HOLD_CYCLES = 16'(`STRAP_HOLD_CYC)
) (
	// clock, reset, enable
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         clkEn,
	// power-up pin
	input  wire logic         powerUpEnablePin,
	// strap pins: first, second, sample edge, drive edge, debug
	input  wire logic [4:0]   strapPinIn,
	output var  logic [4:0]   strapPinOut,
	output var  logic [4:0]   strapPinOe,
	output var  logic         bootStrapSecondPullUp,
	// fuses, same clock domain
	input  wire logic [1:0]   bootPrintFuse,
	input  wire logic         padDebugDisableFuse,
	input  wire logic         usbDebugDisableFuse,
	input  wire logic         debugSourceSelectFuse,
	// decoded configuration
	output var  logic         deviceActive,
	output var  logic         configValid,
	output var  bootMode_t    bootMode,
	output var  logic         sdioSampleRise,
	output var  logic         sdioDriveRise,
	output var  logic         bootPrintEnable,
	output var  debugSource_t debugSource,
	// AXI4-Lite write
	input  wire logic [3:0]   awaddr,
	input  wire logic         awvalid,
	output var  logic         awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output var  logic         wready,
	output var  logic [1:0]   bresp,
	output var  logic         bvalid,
	input  wire logic         bready,
	// AXI4-Lite read
	input  wire logic [3:0]   araddr,
	input  wire logic         arvalid,
	output var  logic         arready,
	output var  logic [31:0]  rdata,
	output var  logic [1:0]   rresp,
	output var  logic         rvalid,
	input  wire logic         rready
);

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	function automatic bootMode_t decodeBoot(input strapVec_t s);
		if (s[`STRAP_BOOT_SECOND])
			decodeBoot = BOOT_FLASH;
		else if (s[`STRAP_BOOT_FIRST])
			decodeBoot = BOOT_DOWNLOAD;
		else
			decodeBoot = BOOT_UNDEFINED;
	endfunction

	function automatic logic decodePrint(input logic [1:0] f, input logic first);
		case (f)
			2'h0: decodePrint = 1'b1;
			2'h1: decodePrint = !first;
			2'h2: decodePrint = first;
			default: decodePrint = 1'b0;
		endcase
	endfunction

	function automatic debugSource_t decodeDebug(input logic padDis, input logic usbDis,
		input logic sel, input logic strap);
		if (padDis && usbDis)
			decodeDebug = DBG_OFF;
		else if (padDis)
			decodeDebug = DBG_USB;
		else if (usbDis)
			decodeDebug = DBG_PADS;
		else if (sel && !strap)
			decodeDebug = DBG_PADS;
		else
			decodeDebug = DBG_USB;
	endfunction

	function automatic logic isAddr(input logic [3:0] a, input logic [3:0] r);
		isAddr = (a == r);
	endfunction

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	logic [5:0] pinSync;
	logic       powerSync;
	strapVec_t  strapSync;

	strap_pin_sync u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.clkEn    (clkEn),
		.pinAsync ({powerUpEnablePin, strapPinIn}),
		.pinSync  (pinSync)
	);

	assign powerSync = pinSync[5];
	assign strapSync = pinSync[4:0];

	// ----------------------------------------------------------------
	// power sequencing and strap capture
	// ----------------------------------------------------------------
	pwrState_t    state_q;
	pwrState_t    state_d;
	logic [15:0]  holdCnt_q;
	logic [15:0]  holdCnt_d;
	strapVec_t    latched_q;
	strapVec_t    latched_d;
	logic         valid_q;
	logic         valid_d;
	bootMode_t    boot_q;
	bootMode_t    boot_d;
	logic         sample_q;
	logic         sample_d;
	logic         drive_q;
	logic         drive_d;
	logic         print_q;
	logic         print_d;
	debugSource_t dbg_q;
	debugSource_t dbg_d;
	logic         active_q;
	logic         active_d;
	logic         pullUp_q;
	logic         pullUp_d;

	always_comb begin
		state_d   = state_q;
		holdCnt_d = holdCnt_q;
		latched_d = latched_q;
		valid_d   = valid_q;
		boot_d    = boot_q;
		sample_d  = sample_q;
		drive_d   = drive_q;
		print_d   = print_q;
		dbg_d     = dbg_q;
		if (clkEn) begin
			case (state_q)
				PWR_OFF: begin
					holdCnt_d = 16'h0000;
					if (powerSync)
						state_d = PWR_HOLD;
				end
				PWR_HOLD: begin
					if (!powerSync) begin
						state_d = PWR_OFF;
					end else if (holdCnt_q == HOLD_CYCLES - 16'h0001) begin
						// straps must stand still through the whole hold
						state_d   = PWR_RUN;
						latched_d = strapSync;
						valid_d   = 1'b1;
						boot_d    = decodeBoot(strapSync);
						sample_d  = strapSync[`STRAP_SAMPLE_EDGE];
						drive_d   = strapSync[`STRAP_DRIVE_EDGE];
						print_d   = decodePrint(bootPrintFuse,
							strapSync[`STRAP_BOOT_FIRST]);
						dbg_d     = decodeDebug(padDebugDisableFuse, usbDebugDisableFuse,
							debugSourceSelectFuse, strapSync[`STRAP_DEBUG_SRC]);
					end else begin
						holdCnt_d = holdCnt_q + 16'h0001;
					end
				end
				PWR_RUN: begin
					// latched values only leave on power-down
					if (!powerSync)
						state_d = PWR_OFF;
				end
				default: state_d = PWR_OFF;
			endcase
			if (state_d == PWR_OFF) begin
				latched_d = `LATCH_RESET;
				valid_d   = 1'b0;
				boot_d    = BOOT_UNDEFINED;
				sample_d  = 1'b0;
				drive_d   = 1'b0;
				print_d   = 1'b0;
				dbg_d     = DBG_OFF;
			end
		end
		active_d = (state_d != PWR_OFF);
		pullUp_d = (state_d != PWR_RUN);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q   <= PWR_OFF;
			holdCnt_q <= 16'h0000;
			latched_q <= `LATCH_RESET;
			valid_q   <= 1'b0;
			boot_q    <= BOOT_UNDEFINED;
			sample_q  <= 1'b0;
			drive_q   <= 1'b0;
			print_q   <= 1'b0;
			dbg_q     <= DBG_OFF;
			active_q  <= 1'b0;
			pullUp_q  <= 1'b1;
		end else begin
			state_q   <= state_d;
			holdCnt_q <= holdCnt_d;
			latched_q <= latched_d;
			valid_q   <= valid_d;
			boot_q    <= boot_d;
			sample_q  <= sample_d;
			drive_q   <= drive_d;
			print_q   <= print_d;
			dbg_q     <= dbg_d;
			active_q  <= active_d;
			pullUp_q  <= pullUp_d;
		end
	end

	// ----------------------------------------------------------------
	// register slave and general-purpose pin drive
	// ----------------------------------------------------------------
	logic        awTaken_q;
	logic        awTaken_d;
	logic [3:0]  awAddr_q;
	logic [3:0]  awAddr_d;
	logic        wTaken_q;
	logic        wTaken_d;
	logic [31:0] wData_q;
	logic [31:0] wData_d;
	logic        wLow_q;
	logic        wLow_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic [4:0]  gpioOut_q;
	logic [4:0]  gpioOut_d;
	logic [4:0]  gpioOe_q;
	logic [4:0]  gpioOe_d;
	logic [4:0]  pinOut_q;
	logic [4:0]  pinOut_d;
	logic [4:0]  pinOe_q;
	logic [4:0]  pinOe_d;
	logic [31:0] statusWord;
	logic        awReady_q;
	logic        wReady_q;
	logic        arReady_q;

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`ST_ACTIVE_BIT]              = active_q;
		statusWord[`ST_VALID_BIT]               = valid_q;
		statusWord[`ST_BOOT_LSB +: 2]           = boot_q;
		statusWord[`ST_SAMPLE_BIT]              = sample_q;
		statusWord[`ST_DRIVE_BIT]               = drive_q;
		statusWord[`ST_PRINT_BIT]               = print_q;
		statusWord[`ST_DEBUG_LSB +: 2]          = dbg_q;
	end

	always_comb begin
		awTaken_d = awTaken_q;
		awAddr_d  = awAddr_q;
		wTaken_d  = wTaken_q;
		wData_d   = wData_q;
		wLow_d    = wLow_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		gpioOut_d = gpioOut_q;
		gpioOe_d  = gpioOe_q;
		if (clkEn) begin
			if (awvalid && awReady_q) begin
				awTaken_d = 1'b1;
				awAddr_d  = awaddr;
			end
			if (wvalid && wReady_q) begin
				wTaken_d = 1'b1;
				wData_d  = wdata;
				wLow_d   = wstrb[0] | wstrb[1];
			end
			if (awTaken_q && wTaken_q) begin
				awTaken_d = 1'b0;
				wTaken_d  = 1'b0;
				bvalid_d  = 1'b1;
				bresp_d   = 2'h0;
				// strap latches have no write path at all
				if (isAddr(awAddr_q, `REG_GPIO_OUT)) begin
					if (wLow_q) begin
						gpioOut_d = wData_q[4:0];
						gpioOe_d  = wData_q[`GPIO_OE_LSB +: 5];
					end
				end else if (isAddr(awAddr_q, `REG_STATUS) ||
					isAddr(awAddr_q, `REG_LATCHED) || isAddr(awAddr_q, `REG_PIN_LEVEL)) begin
					bresp_d = 2'h0;
				end else begin
					bresp_d = 2'h2;
				end
			end
			if (bvalid_q && bready)
				bvalid_d = 1'b0;
			if (arvalid && arReady_q) begin
				rvalid_d = 1'b1;
				rresp_d  = 2'h0;
				if (isAddr(araddr, `REG_STATUS)) begin
					rdata_d = statusWord;
				end else if (isAddr(araddr, `REG_LATCHED)) begin
					rdata_d = {27'h0, latched_q};
				end else if (isAddr(araddr, `REG_PIN_LEVEL)) begin
					rdata_d = {27'h0, strapSync};
				end else if (isAddr(araddr, `REG_GPIO_OUT)) begin
					rdata_d = {19'h0, gpioOe_q, 3'h0, gpioOut_q};
				end else begin
					rdata_d = 32'h0000_0000;
					rresp_d = 2'h2;
				end
			end else if (rvalid_q && rready) begin
				rvalid_d = 1'b0;
			end
		end
		// pins stay released until the hold ends, then act as plain IO
		pinOut_d = (state_d == PWR_RUN) ? gpioOut_d : 5'h00;
		pinOe_d  = (state_d == PWR_RUN) ? gpioOe_d : 5'h00;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awTaken_q <= 1'b0;
			awAddr_q  <= 4'h0;
			wTaken_q  <= 1'b0;
			wData_q   <= 32'h0000_0000;
			wLow_q    <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= 2'h0;
			gpioOut_q <= `GPIO_OUT_RESET;
			gpioOe_q  <= `GPIO_OE_RESET;
			pinOut_q  <= 5'h00;
			pinOe_q   <= 5'h00;
		end else begin
			awTaken_q <= awTaken_d;
			awAddr_q  <= awAddr_d;
			wTaken_q  <= wTaken_d;
			wData_q   <= wData_d;
			wLow_q    <= wLow_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			gpioOut_q <= gpioOut_d;
			gpioOe_q  <= gpioOe_d;
			pinOut_q  <= pinOut_d;
			pinOe_q   <= pinOe_d;
		end
	end

	// ready is the inverse of a held flag, so it comes from a flip-flop too;
	// the takes above use it, so no beat is taken before ready shows high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			awReady_q <= 1'b0;
			wReady_q  <= 1'b0;
			arReady_q <= 1'b0;
		end else if (clkEn) begin
			awReady_q <= !awTaken_d && !bvalid_d && !(awvalid && awReady_q && clkEn);
			wReady_q  <= !wTaken_d && !bvalid_d && !(wvalid && wReady_q && clkEn);
			arReady_q <= !rvalid_d && !(arvalid && arReady_q && clkEn);
		end
	end

	assign strapPinOut           = pinOut_q;
	assign strapPinOe            = pinOe_q;
	assign bootStrapSecondPullUp = pullUp_q;
	assign deviceActive          = active_q;
	assign configValid           = valid_q;
	assign bootMode              = boot_q;
	assign sdioSampleRise        = sample_q;
	assign sdioDriveRise         = drive_q;
	assign bootPrintEnable       = print_q;
	assign debugSource           = dbg_q;
	assign awready               = awReady_q;
	assign wready                = wReady_q;
	assign bresp                 = bresp_q;
	assign bvalid                = bvalid_q;
	assign arready               = arReady_q;
	assign rdata                 = rdata_q;
	assign rresp                 = rresp_q;
	assign rvalid                = rvalid_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence enterRun;
		state_q == PWR_RUN && $past(state_q) == PWR_HOLD;
	endsequence

	sequence stayRun;
		state_q == PWR_RUN && $past(state_q) == PWR_RUN;
	endsequence

	AST_CAPTURE: assert property (enterRun |-> latched_q == $past(strapSync))
		else $error("straps not captured at end of hold");
	AST_HOLD_TIME: assert property (enterRun |-> $past(holdCnt_q) == HOLD_CYCLES - 16'h0001)
		else $error("pins released before the hold interval");
	AST_LATCH_STABLE: assert property (stayRun |-> $stable(latched_q) && $stable(boot_q)
		&& $stable(print_q) && $stable(dbg_q))
		else $error("latched configuration changed while running");
	AST_POWER_DOWN: assert property (clkEn && !powerSync |=> state_q == PWR_OFF
		&& !deviceActive && !configValid)
		else $error("device stayed active with power pin low");
	AST_ACTIVE: assert property (state_q == PWR_RUN |-> deviceActive && configValid)
		else $error("running device not shown active");
	AST_RELEASED: assert property (state_q != PWR_RUN |-> strapPinOe == 5'h00)
		else $error("strap pin driven before hand-over");
	AST_PULLUP: assert property (bootStrapSecondPullUp == (state_q != PWR_RUN))
		else $error("pull-up state does not follow reset phase");
	AST_FLASH: assert property (configValid && latched_q[`STRAP_BOOT_SECOND]
		|-> bootMode == BOOT_FLASH)
		else $error("second strap high did not select flash boot");
	AST_DOWNLOAD: assert property (configValid && latched_q[1:0] == 2'h1
		|-> bootMode == BOOT_DOWNLOAD)
		else $error("download boot not decoded");
	AST_UNDEF: assert property (configValid && latched_q[1:0] == 2'h0
		|-> bootMode == BOOT_UNDEFINED)
		else $error("undefined boot combination not flagged");
	AST_EDGES: assert property (configValid |-> sdioSampleRise == latched_q[`STRAP_SAMPLE_EDGE]
		&& sdioDriveRise == latched_q[`STRAP_DRIVE_EDGE])
		else $error("sdio edge selection disagrees with latch");
	AST_PRINT: assert property (enterRun ##0 $past(bootPrintFuse) == 2'h3
		|-> !bootPrintEnable)
		else $error("print not disabled by fuse 11");
	AST_DEBUG: assert property (enterRun ##0 ($past(debugSourceSelectFuse)
		&& !$past(padDebugDisableFuse) && !$past(usbDebugDisableFuse))
		|-> debugSource == (latched_q[`STRAP_DEBUG_SRC] ? DBG_USB : DBG_PADS))
		else $error("debug source not taken from debug strap");

endmodule
`default_nettype wire

// file: src/strap_pin_sync.sv
// two-stage synchroniser for the power pin and the strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_pin_sync (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// pins in, synchronised levels out
	input  wire logic [5:0] pinAsync,
	output var  logic [5:0] pinSync
);

	logic [5:0] meta_q;
	logic [5:0] meta_d;
	logic [5:0] sync_q;
	logic [5:0] sync_d;

	always_comb begin
		meta_d = clkEn ? pinAsync : meta_q;
		sync_d = clkEn ? meta_q : sync_q;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= 6'h00;
			sync_q <= 6'h00;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pinSync = sync_q;

endmodule
`default_nettype wire

// file: tb/strap_board_model.sv
// board resistors and host drive seen on the five strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
	// clock
	input  wire logic       clk_sys,
	// board drive of each strap
	input  wire logic [4:0] drvVal,
	input  wire logic [4:0] drvEn,
	// device side of the pins
	input  wire logic [4:0] pinOut,
	input  wire logic [4:0] pinOe,
	input  wire logic       pullUp,
	output var  logic [4:0] pinLevel
);
	// undriven, unpulled pins wander so a stale level never passes for a good one
	logic [4:0] wander = 5'h15;

	always @(posedge clk_sys) wander <= ~wander;

	always_comb begin
		for (int b = 0; b < 5; b++) begin
			if (pinOe[b])
				pinLevel[b] = pinOut[b];
			else if (drvEn[b])
				pinLevel[b] = drvVal[b];
			else if (b == 1 && pullUp)
				pinLevel[b] = 1'b1;
			else
				pinLevel[b] = wander[b];
		end
	end
endmodule
`default_nettype wire

// file: tb/strap_latch_boot_config_test.sv
// self-checking bench for the strap latch and boot configuration block
`timescale 1ns/1ps
`default_nettype none
module strap_latch_boot_config_test;
	import strap_latch_pkg::*;

	logic         clk_sys = 1'b0;
	logic         rst, clkEn, pwr, bootStrapSecondPullUp, padDis, usbDis, selFuse;
	logic [4:0]   drvVal, drvEn, pinLevel, strapPinOut, strapPinOe;
	logic [1:0]   bootPrintFuse, bresp, rresp;
	logic         deviceActive, configValid, sdioSampleRise, sdioDriveRise, bootPrintEnable;
	bootMode_t    bootMode;
	debugSource_t debugSource;
	logic [3:0]   awaddr, wstrb, araddr;
	logic [31:0]  wdata, rdata, seed;
	logic         awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready, cfgPrev = 1'b0;
	logic [6:0]   cfgNow;
	logic [6:0]   expCfgQ[$];
	logic [33:0]  expRdQ[$];
	int           n_mismatch = 0;
	int           total_checks = 0;

	always #25 clk_sys = ~clk_sys;
	assign cfgNow = {bootMode, sdioSampleRise, sdioDriveRise, bootPrintEnable, debugSource};

	strap_latch_boot_config #(.HOLD_CYCLES(16'h0008)) strap_latch_boot_config_i (
		.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .powerUpEnablePin(pwr),
		.strapPinIn(pinLevel), .strapPinOut(strapPinOut), .strapPinOe(strapPinOe),
		.bootStrapSecondPullUp(bootStrapSecondPullUp), .bootPrintFuse(bootPrintFuse),
		.padDebugDisableFuse(padDis), .usbDebugDisableFuse(usbDis),
		.debugSourceSelectFuse(selFuse), .deviceActive(deviceActive),
		.configValid(configValid), .bootMode(bootMode), .sdioSampleRise(sdioSampleRise),
		.sdioDriveRise(sdioDriveRise), .bootPrintEnable(bootPrintEnable),
		.debugSource(debugSource), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	strap_board_model strap_board_model_i (
		.clk_sys(clk_sys), .drvVal(drvVal), .drvEn(drvEn), .pinOut(strapPinOut),
		.pinOe(strapPinOe), .pullUp(bootStrapSecondPullUp), .pinLevel(pinLevel));

	// ----------------------------------------------------------------
	// compare, report, bus tasks
	// ----------------------------------------------------------------
	task automatic checkVal(input string name, input logic [33:0] exp, input logic [33:0] got);
		total_checks++;
		if (exp !== got) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		checkVal("bresp", 3'b100, {bvalid, bresp});
	endtask

	task automatic axiRead(input logic [3:0] a);
		int n;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		checkVal("rvalid", 1, rvalid);
	endtask

	// results are compared in the order they were promised
	always @(posedge clk_sys) begin
		cfgPrev <= configValid;
		if (configValid && !cfgPrev)
			checkVal("config", expCfgQ.size() ? expCfgQ.pop_front() : 7'h7F, cfgNow);
		if (rvalid && rready)
			checkVal("rdata", expRdQ.size() ? expRdQ.pop_front() : 34'h3, {rresp, rdata});
	end

	// ----------------------------------------------------------------
	// one power cycle with its own strap and fuse setting
	// ----------------------------------------------------------------
	task automatic powerCycle(input int i);
		logic [31:0] r;
		strapVec_t   s;
		logic [6:0]  c;
		int          n;
		r = $random(seed);
		s = {r[4:2], ((i == 1) ? 1'b1 : i[1]), i[0]};
		c[6:5] = s[1] ? BOOT_FLASH : (s[0] ? BOOT_DOWNLOAD : BOOT_UNDEFINED);
		c[4] = s[2];
		c[3] = s[3];
		c[2] = (i[2:1] == 0) | (i[2:1] == 1 & !s[0]) | (i[2:1] == 2 & s[0]);
		c[1:0] = (r[5] & r[6]) ? DBG_OFF : (r[6] ? DBG_PADS :
			((r[5] | !r[7] | s[4]) ? DBG_USB : DBG_PADS));
		expCfgQ.push_back(c);
		@(posedge clk_sys);
		drvVal <= {r[4:2], i[1:0]};
		drvEn <= (i == 1) ? 5'h1D : 5'h1F;
		bootPrintFuse <= i[2:1];
		{selFuse, usbDis, padDis} <= r[7:5];
		repeat (3) @(posedge clk_sys);
		pwr <= 1'b1;
		n = 0;
		while (!configValid && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		checkVal("holdWait", 1, n > 8 && n < 40);
		checkVal("active", 1, deviceActive);
		expRdQ.push_back({25'h0, c[1:0], c[2], c[3], c[4], c[6:5], 2'b11});
		axiRead(4'h0);
		expRdQ.push_back({29'h0, s});
		axiRead(4'h4);
		axiWrite(4'h4, 32'hFFFFFFFF);
		axiWrite(4'hC, {19'h0, r[12:8], 3'h0, r[20:16]});
		@(posedge clk_sys);
		checkVal("gpioOe", r[12:8], strapPinOe);
		checkVal("gpioOut", r[20:16], strapPinOut);
		drvVal <= r[25:21];
		drvEn <= 5'h1F;
		repeat (4) @(posedge clk_sys);
		checkVal("configHeld", c, cfgNow);
		expRdQ.push_back({29'h0, s});
		axiRead(4'h4);
		expRdQ.push_back({29'h0, (r[12:8] & r[20:16]) | (~r[12:8] & r[25:21])});
		axiRead(4'h8);
		expRdQ.push_back({2'h2, 32'h0});
		axiRead(4'h2);
		clkEn <= 1'b0;
		pwr <= 1'b0;
		repeat (4) @(posedge clk_sys);
		checkVal("frozen", 2'b11, {deviceActive, configValid});
		clkEn <= 1'b1;
		n = 0;
		while (deviceActive && n < 10) begin
			@(posedge clk_sys);
			n++;
		end
		@(posedge clk_sys);
		checkVal("offState", 4'b0001, {deviceActive, configValid, |strapPinOe,
			bootStrapSecondPullUp});
	endtask

	initial begin
		seed = 32'hFBA7;
		rst = 1'b1;
		clkEn = 1'b1;
		pwr = 1'b0;
		drvVal = 5'h00;
		drvEn = 5'h1F;
		bootPrintFuse = 2'h0;
		{padDis, usbDis, selFuse} = 3'h0;
		{awaddr, araddr, wstrb, wdata} = 44'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		repeat (2) @(posedge clk_sys);
		checkVal("resetPins", 2'b01, {deviceActive, bootStrapSecondPullUp});
		@(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			powerCycle(i);
		checkVal("queuesLeft", 0, expCfgQ.size() + expRdQ.size());
		tally_and_finish;
	end

	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
